// ### hdl/pdwc_crc.v
`timescale 1ns/100ps
`include "pdwc_map.vh"
module pdwc_crc (
	// clock and reset
	input wire clk_sys,
	input wire rst,
	// format controls
	input wire [1:0] mode,
	input wire in_rev,
	input wire out_rev,
	input wire in_com,
	input wire out_com,
	// seed load and byte feed
	input wire [31:0] seed,
	input wire load,
	input wire feed,
	input wire [31:0] fdata,
	input wire [2:0] fbytes,
	// state
	output wire busy,
	output wire [31:0] result
);
	reg [31:0] crc;
	reg [31:0] sh;
	reg [2:0] left;
	wire [31:0] raw;
	wire [31:0] rv;

	function [31:0] wmask;
		input [1:0] m;
		begin
			case (m)
				`PDWC_P_C8: wmask = 32'h000000ff;
				`PDWC_P_C32: wmask = 32'hffffffff;
				default: wmask = 32'h0000ffff;
			endcase
		end
	endfunction

	function [31:0] poly;
		input [1:0] m;
		begin
			case (m)
				`PDWC_P_C8: poly = `PDWC_POLY_C8;
				`PDWC_P_C16: poly = `PDWC_POLY_C16;
				`PDWC_P_C32: poly = `PDWC_POLY_C32;
				default: poly = `PDWC_POLY_CCITT;
			endcase
		end
	endfunction

	// one byte, msb first, through the selected polynomial
	function [31:0] crc_byte;
		input [31:0] c;
		input [7:0] d;
		input [1:0] m;
		integer i;
		reg [31:0] r;
		reg fb;
		begin
			r = c;
			for (i = 7; i >= 0; i = i - 1) begin
				fb = ((m == `PDWC_P_C8) ? r[7] : (m == `PDWC_P_C32) ? r[31] : r[15]) ^ d[i];
				r = ((r << 1) ^ (fb ? poly(m) : 32'h0)) & wmask(m);
			end
			crc_byte = r;
		end
	endfunction

	function [31:0] rev32;
		input [31:0] v;
		integer i;
		begin
			for (i = 0; i < 32; i = i + 1)
				rev32[i] = v[31 - i];
		end
	endfunction

	// input reversal and complement per byte
	function [7:0] prep;
		input [7:0] b;
		input rv_on;
		input cm_on;
		reg [31:0] t;
		begin
			t = rv_on ? rev32({b, 24'h0}) : {24'h0, b};
			prep = t[7:0] ^ (cm_on ? 8'hff : 8'h00);
		end
	endfunction

	assign busy = (left != 3'h0);
	// result reversal over the active width, then complement
	assign raw = crc & wmask(mode);
	assign rv = rev32(raw) >> ((mode == `PDWC_P_C8) ? 24 : (mode == `PDWC_P_C32) ? 0 : 16);
	assign result = (out_rev ? rv : raw) ^ (out_com ? wmask(mode) : 32'h0);

	// first byte handled on the feed edge, so a byte costs one clock
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			crc <= `PDWC_SEED_RST;
			sh <= 32'h0;
			left <= 3'h0;
		end else if (load) begin
			crc <= seed & wmask(mode);
			left <= 3'h0;
		end else if (feed && !busy) begin
			crc <= crc_byte(crc, prep(fdata[7:0], in_rev, in_com), mode);
			sh <= fdata >> 8;
			left <= fbytes - 3'h1;
		end else if (busy) begin
			crc <= crc_byte(crc, prep(sh[7:0], in_rev, in_com), mode);
			sh <= sh >> 8;
			left <= left - 3'h1;
		end
	end
endmodule

// ### hdl/pdwc_map.vh
`ifndef PDWC_MAP_VH
`define PDWC_MAP_VH
// ****************************************
// address map
// ****************************************
// channel n words at byte 0x000 + n*0x20
`define PDWC_RG_NONE 2'h0
`define PDWC_RG_CH 2'h1
`define PDWC_RG_CRC 2'h2
`define PDWC_RG_SEL 2'h3
`define PDWC_NCH 4'h9
`define PDWC_CRC_PAGE 4'h2
`define PDWC_SEL_PAGE 4'h3
`define PDWC_R_CTL 3'h0
`define PDWC_R_SRC 3'h1
`define PDWC_R_DST 3'h2
`define PDWC_R_CNT 3'h3
`define PDWC_R_REM 3'h4
`define PDWC_R_IEN 3'h5
`define PDWC_R_STS 3'h6
// checksum words at byte 0x200
`define PDWC_K_CTLW 3'h0
`define PDWC_K_SRCW 3'h1
`define PDWC_K_LENW 3'h2
`define PDWC_K_SEEDW 3'h3
`define PDWC_K_DATAW 3'h4
`define PDWC_K_RESW 3'h5
`define PDWC_K_STSW 3'h6
`define PDWC_K_IENW 3'h7
// service selects at 0x300..0x308, flag summary at 0x30c
`define PDWC_SUMW 2'h3
// ****************************************
// channel control fields
// ****************************************
`define PDWC_C_EN 0
`define PDWC_C_SRST 1
`define PDWC_C_MODE 2
`define PDWC_C_SDIR 4
`define PDWC_C_DDIR 6
`define PDWC_C_PW 19
`define PDWC_C_TRIG 23
`define PDWC_C_MASK 32'h009800fd
`define PDWC_M_MEM 2'h0
`define PDWC_M_M2P 2'h1
`define PDWC_M_P2M 2'h2
`define PDWC_W_WORD 2'h0
`define PDWC_W_BYTE 2'h1
`define PDWC_W_HALF 2'h2
`define PDWC_SZ_BYTE 2'h0
`define PDWC_SZ_HALF 2'h1
`define PDWC_SZ_WORD 2'h2
// ****************************************
// checksum control fields
// ****************************************
`define PDWC_K_EN 0
`define PDWC_K_RST 1
`define PDWC_K_TRIG 23
`define PDWC_K_IREV 24
`define PDWC_K_OREV 25
`define PDWC_K_ICOM 26
`define PDWC_K_OCOM 27
`define PDWC_K_WLEN 28
`define PDWC_K_MODE 30
`define PDWC_K_MASK 32'hff800001
`define PDWC_CW_BYTE 2'h0
`define PDWC_CW_HALF 2'h1
`define PDWC_P_CCITT 2'h0
`define PDWC_P_C8 2'h1
`define PDWC_P_C16 2'h2
`define PDWC_P_C32 2'h3
`define PDWC_POLY_CCITT 32'h00001021
`define PDWC_POLY_C8 32'h00000007
`define PDWC_POLY_C16 32'h00008005
`define PDWC_POLY_C32 32'h04c11db7
`define PDWC_SEED_RST 32'hffffffff
`define PDWC_OKAY 2'h0
`define PDWC_SLVERR 2'h2
`endif

// ### hdl/pdwc_top.v
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "pdwc_map.vh"
// Notes on behaviour
// - nine transfer channels plus one checksum channel, any move direction
// - source and destination addresses each increment or stay fixed
// - triggered channel moves items, counting down, ends at zero
// - done sets a flag, raises interrupt if enabled, write one clears
// - a bus error halts the channel until software acts
// - control holds source and destination direction and move mode
// - per channel peripheral side item width
// - bits 31:30 pick CCITT, CRC-8, CRC-16 or CRC-32
// - enable with trigger clear is CPU mode, trigger set is DMA mode
// - bits 24..27 reverse and complement input and result
// - bits 29:28 give the CPU write width
// - bit 1 loads the seed, keeps other bits, self clears
// - writable 32-bit seed register
// - each feed write advances, result register shows checksum
// - DMA checksum run end sets the checksum done flag
// - completion seen by polling flags or by the interrupt line
// - fixed priority, channel 0 first, checksum channel last
// - one word buffer between read and write side
// - CPU byte write takes one clock, half two, word four
// - clearing channel enable stops a transfer in progress
module pdwc_top (
	// clock and reset
	input wire clk_sys,
	input wire rst,
	// axi4-lite register slave
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// data mover bus master
	output reg m_req,
	output reg m_write,
	output reg [31:0] m_addr,
	output reg [1:0] m_size,
	output reg [31:0] m_wdata,
	input wire m_ack,
	input wire [31:0] m_rdata,
	input wire m_err,
	// peripheral service requests
	input wire [15:0] per_req,
	// completion interrupt
	output reg irq
);
	localparam E_IDLE = 2'h0;
	localparam E_RD = 2'h1;
	localparam E_WR = 2'h2;
	localparam E_FEED = 2'h3;

	// ****************************************
	// state
	// ****************************************
	// nine channel register sets
	reg [31:0] ch_ctl [0:8];
	reg [31:0] ch_src [0:8];
	reg [31:0] ch_dst [0:8];
	reg [15:0] ch_cnt [0:8];
	reg [31:0] cur_src [0:8];
	reg [31:0] cur_dst [0:8];
	reg [15:0] cur_cnt [0:8];
	reg [31:0] sel_r [0:2];
	reg [8:0] ch_ien;
	reg [9:0] done_f;
	reg [9:0] err_f;
	reg [9:0] done_set;
	reg [9:0] err_set;
	reg [9:0] clr_done;
	reg [9:0] clr_err;
	reg [9:0] elig;
	reg [31:0] k_ctl;
	reg [31:0] k_seed;
	reg [31:0] k_src;
	reg [31:0] k_data;
	reg [15:0] k_len;
	reg [31:0] k_cur;
	reg [15:0] k_rem;
	reg k_ien;
	reg k_load;
	reg k_fv;
	reg [31:0] k_fd;
	reg [2:0] k_fn;
	reg [31:0] hold;
	reg [1:0] est;
	reg [3:0] eid;
	reg [11:0] aw_a;
	reg [31:0] w_d;
	reg [3:0] w_s;
	integer ei;
	wire crc_busy;
	wire [31:0] crc_res;
	wire [4:0] pk;
	wire [3:0] pid;
	wire [3:0] wc;
	wire [32:0] wr_old;
	wire [31:0] wr_new;
	wire wr_stall;
	wire wr_go;
	wire [32:0] rd_val;
	wire [2:0] stp;

	// ****************************************
	// helpers
	// ****************************************
	function [1:0] region;
		input [11:0] a;
		begin
			if (a[11:9] == 3'h0 && a[8:5] < `PDWC_NCH)
				region = `PDWC_RG_CH;
			else if (a[11:8] == `PDWC_CRC_PAGE && a[7:5] == 3'h0)
				region = `PDWC_RG_CRC;
			else if (a[11:8] == `PDWC_SEL_PAGE && a[7:4] == 4'h0)
				region = `PDWC_RG_SEL;
			else
				region = `PDWC_RG_NONE;
		end
	endfunction

	// register view {valid, data} shared by reads and write merging
	function [32:0] rd_reg;
		input [11:0] a;
		reg [3:0] c;
		begin
			c = a[8:5];
			rd_reg = {1'b1, 32'h0};
			case (region(a))
				`PDWC_RG_CH: begin
					case (a[4:2])
						`PDWC_R_CTL: rd_reg[31:0] = ch_ctl[c];
						`PDWC_R_SRC: rd_reg[31:0] = ch_src[c];
						`PDWC_R_DST: rd_reg[31:0] = ch_dst[c];
						`PDWC_R_CNT: rd_reg[15:0] = ch_cnt[c];
						`PDWC_R_REM: rd_reg[15:0] = cur_cnt[c];
						`PDWC_R_IEN: rd_reg[0] = ch_ien[c];
						`PDWC_R_STS: rd_reg[1:0] = {err_f[c], done_f[c]};
						default: rd_reg[32] = 1'b0;
					endcase
				end
				`PDWC_RG_CRC: begin
					case (a[4:2])
						`PDWC_K_CTLW: rd_reg[31:0] = k_ctl;
						`PDWC_K_SRCW: rd_reg[31:0] = k_src;
						`PDWC_K_LENW: rd_reg[15:0] = k_len;
						`PDWC_K_SEEDW: rd_reg[31:0] = k_seed;
						`PDWC_K_DATAW: rd_reg[31:0] = k_data;
						`PDWC_K_RESW: rd_reg[31:0] = crc_res;
						`PDWC_K_STSW: rd_reg[1:0] = {err_f[9], done_f[9]};
						default: rd_reg[0] = k_ien;
					endcase
				end
				`PDWC_RG_SEL: begin
					if (a[3:2] == `PDWC_SUMW)
						rd_reg[19:0] = {err_f, done_f};
					else
						rd_reg[31:0] = sel_r[a[3:2]];
				end
				default: rd_reg[32] = 1'b0;
			endcase
		end
	endfunction

	function [31:0] merge;
		input [31:0] o;
		input [31:0] n;
		input [3:0] s;
		integer b;
		begin
			merge = o;
			for (b = 0; b < 4; b = b + 1)
				if (s[b])
					merge[b * 8 +: 8] = n[b * 8 +: 8];
		end
	endfunction

	function [4:0] prio;
		input [9:0] v;
		integer i;
		begin
			prio = 5'h0;
			for (i = 9; i >= 0; i = i - 1)
				if (v[i])
					prio = {1'b1, i[3:0]};
		end
	endfunction

	// item size from the peripheral width field
	function [1:0] wsize;
		input [1:0] w;
		begin
			case (w)
				`PDWC_W_BYTE: wsize = `PDWC_SZ_BYTE;
				`PDWC_W_HALF: wsize = `PDWC_SZ_HALF;
				default: wsize = `PDWC_SZ_WORD;
			endcase
		end
	endfunction

	// ****************************************
	// decode and arbitration
	// ****************************************
	assign wc = aw_a[8:5];
	assign wr_old = rd_reg(aw_a);
	assign wr_new = merge(wr_old[31:0], w_d, w_s);
	assign rd_val = rd_reg(s_axi_araddr);
	// feed writes wait while the checksum circuit is still busy
	assign wr_stall = region(aw_a) == `PDWC_RG_CRC && aw_a[4:2] == `PDWC_K_DATAW && (crc_busy || k_fv);
	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid && !wr_stall;
	assign pk = prio(elig);
	assign pid = pk[3:0];
	assign stp = 3'h1 << wsize(ch_ctl[eid][`PDWC_C_PW +: 2]);

	// eligibility, peripheral modes wait on their selected request
	always @* begin
		elig = 10'h0;
		for (ei = 0; ei < 9; ei = ei + 1)
			elig[ei] = ch_ctl[ei][`PDWC_C_EN] && ch_ctl[ei][`PDWC_C_TRIG] && !err_f[ei] &&
				(ch_ctl[ei][`PDWC_C_MODE +: 2] == `PDWC_M_MEM ||
				per_req[sel_r[ei / 4][(ei % 4) * 8 +: 4]]);
		// dma-fed checksum only with enable and trigger
		elig[9] = k_ctl[`PDWC_K_EN] && k_ctl[`PDWC_K_TRIG] && !err_f[9];
	end

	always @* begin
		clr_done = 10'h0;
		clr_err = 10'h0;
		if (wr_go && region(aw_a) == `PDWC_RG_CH) begin
			if (aw_a[4:2] == `PDWC_R_STS) begin
				clr_done[wc] = w_s[0] & w_d[0];
				clr_err[wc] = w_s[0] & w_d[1];
			end else if (aw_a[4:2] == `PDWC_R_CTL && wr_new[`PDWC_C_SRST]) begin
				clr_done[wc] = 1'b1;
				clr_err[wc] = 1'b1;
			end
		end else if (wr_go && region(aw_a) == `PDWC_RG_CRC && aw_a[4:2] == `PDWC_K_STSW) begin
			clr_done[9] = w_s[0] & w_d[0];
			clr_err[9] = w_s[0] & w_d[1];
		end
	end

	// sticky flags, set beats clear; irq from enabled done flags
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			done_f <= 10'h0;
			err_f <= 10'h0;
			irq <= 1'b0;
		end else begin
			done_f <= (done_f & ~clr_done) | done_set;
			err_f <= (err_f & ~clr_err) | err_set;
			irq <= |(done_f & {k_ien, ch_ien});
		end
	end

	// ****************************************
	// engine and register writes
	// ****************************************
	// register writes come last so software wins a same-cycle clash
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (ei = 0; ei < 9; ei = ei + 1) begin
				ch_ctl[ei] <= 32'h0;
				ch_src[ei] <= 32'h0;
				ch_dst[ei] <= 32'h0;
				ch_cnt[ei] <= 16'h0;
				cur_src[ei] <= 32'h0;
				cur_dst[ei] <= 32'h0;
				cur_cnt[ei] <= 16'h0;
			end
			for (ei = 0; ei < 3; ei = ei + 1)
				sel_r[ei] <= 32'h0;
			ch_ien <= 9'h0;
			k_ctl <= 32'h0;
			k_seed <= `PDWC_SEED_RST;
			k_src <= 32'h0;
			k_data <= 32'h0;
			k_len <= 16'h0;
			k_cur <= 32'h0;
			k_rem <= 16'h0;
			k_ien <= 1'b0;
			k_load <= 1'b0;
			k_fv <= 1'b0;
			k_fd <= 32'h0;
			k_fn <= 3'h0;
			hold <= 32'h0;
			done_set <= 10'h0;
			err_set <= 10'h0;
			est <= E_IDLE;
			eid <= 4'h0;
			m_req <= 1'b0;
			m_write <= 1'b0;
			m_addr <= 32'h0;
			m_size <= `PDWC_SZ_WORD;
			m_wdata <= 32'h0;
			aw_a <= 12'h0;
			w_d <= 32'h0;
			w_s <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PDWC_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `PDWC_OKAY;
		end else begin
			done_set <= 10'h0;
			err_set <= 10'h0;
			k_load <= 1'b0;
			k_fv <= 1'b0;
			case (est)
				E_IDLE: begin
					if (pk[4]) begin
						eid <= pid;
						if (pid == 4'h9) begin
							if (k_rem != 16'h0) begin
								m_req <= 1'b1;
								m_write <= 1'b0;
								m_addr <= k_cur;
								m_size <= `PDWC_SZ_WORD;
								est <= E_RD;
							end else if (!crc_busy && !k_fv) begin
								// run over once the last byte is absorbed
								k_ctl[`PDWC_K_TRIG] <= 1'b0;
								done_set[9] <= 1'b1;
							end
						end else if (cur_cnt[pid] == 16'h0) begin
							ch_ctl[pid][`PDWC_C_TRIG] <= 1'b0;
							done_set[pid] <= 1'b1;
						end else begin
							m_req <= 1'b1;
							m_write <= 1'b0;
							m_addr <= cur_src[pid];
							m_size <= wsize(ch_ctl[pid][`PDWC_C_PW +: 2]);
							est <= E_RD;
						end
					end
				end
				E_RD: begin
					if (m_ack) begin
						m_req <= 1'b0;
						est <= E_IDLE;
						if (m_err) begin
							err_set[eid] <= 1'b1;
							if (eid == 4'h9)
								k_ctl[`PDWC_K_TRIG] <= 1'b0;
							else
								ch_ctl[eid][`PDWC_C_TRIG] <= 1'b0;
						end else if (eid == 4'h9) begin
							hold <= m_rdata;
							if (k_ctl[`PDWC_K_EN])
								est <= E_FEED;
						end else if (ch_ctl[eid][`PDWC_C_EN]) begin
							// only an enabled channel goes on
							// write data register is the one-word buffer
							m_req <= 1'b1;
							m_write <= 1'b1;
							m_addr <= cur_dst[eid];
							m_wdata <= m_rdata;
							est <= E_WR;
						end
					end
				end
				E_WR: begin
					if (m_ack) begin
						m_req <= 1'b0;
						m_write <= 1'b0;
						est <= E_IDLE;
						if (m_err) begin
							err_set[eid] <= 1'b1;
							ch_ctl[eid][`PDWC_C_TRIG] <= 1'b0;
						end else if (ch_ctl[eid][`PDWC_C_EN]) begin
							// fixed when the direction high bit is set
							if (!ch_ctl[eid][`PDWC_C_SDIR + 1])
								cur_src[eid] <= cur_src[eid] + {29'h0, stp};
							if (!ch_ctl[eid][`PDWC_C_DDIR + 1])
								cur_dst[eid] <= cur_dst[eid] + {29'h0, stp};
							// count down, block ends at zero
							if (cur_cnt[eid] <= {13'h0, stp}) begin
								cur_cnt[eid] <= 16'h0;
								ch_ctl[eid][`PDWC_C_TRIG] <= 1'b0;
								done_set[eid] <= 1'b1;
							end else
								cur_cnt[eid] <= cur_cnt[eid] - {13'h0, stp};
						end
					end
				end
				E_FEED: begin
					if (!k_ctl[`PDWC_K_EN])
						est <= E_IDLE;
					else if (!crc_busy && !k_fv) begin
						k_fv <= 1'b1;
						k_fd <= hold;
						k_fn <= (k_rem >= 16'h4) ? 3'h4 : k_rem[2:0];
						k_rem <= (k_rem >= 16'h4) ? k_rem - 16'h4 : 16'h0;
						k_cur <= k_cur + 32'h4;
						est <= E_IDLE;
					end
				end
				default: est <= E_IDLE;
			endcase
			// axi4-lite address and data capture, either order
			if (s_axi_awvalid && s_axi_awready) begin
				aw_a <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_d <= s_axi_wdata;
				w_s <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_old[32] ? `PDWC_OKAY : `PDWC_SLVERR;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				case (region(aw_a))
					`PDWC_RG_CH: begin
						case (aw_a[4:2])
							`PDWC_R_CTL: begin
								// direction, mode and width live here
								if (wr_new[`PDWC_C_SRST]) begin
									ch_ctl[wc] <= 32'h0;
									cur_cnt[wc] <= 16'h0;
								end else begin
									ch_ctl[wc] <= wr_new & `PDWC_C_MASK;
									// every trigger edge loads a new block
									if (wr_new[`PDWC_C_TRIG] && !wr_old[`PDWC_C_TRIG]) begin
										cur_src[wc] <= ch_src[wc];
										cur_dst[wc] <= ch_dst[wc];
										cur_cnt[wc] <= ch_cnt[wc];
									end
								end
							end
							`PDWC_R_SRC: ch_src[wc] <= wr_new;
							`PDWC_R_DST: ch_dst[wc] <= wr_new;
							`PDWC_R_CNT: ch_cnt[wc] <= wr_new[15:0];
							`PDWC_R_IEN: ch_ien[wc] <= wr_new[0];
							default: ;
						endcase
					end
					`PDWC_RG_CRC: begin
						case (aw_a[4:2])
							`PDWC_K_CTLW: begin
								// reset bit pulses a seed load, never stored
								k_ctl <= wr_new & `PDWC_K_MASK;
								k_load <= wr_new[`PDWC_K_RST];
								if (wr_new[`PDWC_K_TRIG] && !wr_old[`PDWC_K_TRIG]) begin
									k_cur <= {k_src[31:2], 2'h0};
									k_rem <= k_len;
								end
							end
							`PDWC_K_SRCW: k_src <= wr_new;
							`PDWC_K_LENW: k_len <= wr_new[15:0];
							`PDWC_K_SEEDW: k_seed <= wr_new;
							`PDWC_K_DATAW: begin
								k_data <= wr_new;
								// cpu feed, width from bits 29:28
								if (k_ctl[`PDWC_K_EN] && !k_ctl[`PDWC_K_TRIG]) begin
									k_fv <= 1'b1;
									k_fd <= wr_new;
									case (k_ctl[`PDWC_K_WLEN +: 2])
										`PDWC_CW_BYTE: k_fn <= 3'h1;
										`PDWC_CW_HALF: k_fn <= 3'h2;
										default: k_fn <= 3'h4;
									endcase
								end
							end
							`PDWC_K_IENW: k_ien <= wr_new[0];
							default: ;
						endcase
					end
					`PDWC_RG_SEL: begin
						// service selects, summary word is read only
						if (aw_a[3:2] != `PDWC_SUMW)
							sel_r[aw_a[3:2]] <= wr_new;
					end
					default: ;
				endcase
			end
			// axi4-lite read, one cycle to rvalid
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val[31:0];
				s_axi_rresp <= rd_val[32] ? `PDWC_OKAY : `PDWC_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ****************************************
	// checksum circuit
	// ****************************************
	// polynomial select feeds the circuit directly
	pdwc_crc u_crc (
		.clk_sys(clk_sys),
		.rst(rst),
		.mode(k_ctl[`PDWC_K_MODE +: 2]),
		.in_rev(k_ctl[`PDWC_K_IREV]),
		.out_rev(k_ctl[`PDWC_K_OREV]),
		.in_com(k_ctl[`PDWC_K_ICOM]),
		.out_com(k_ctl[`PDWC_K_OCOM]),
		.seed(k_seed),
		.load(k_load),
		.feed(k_fv),
		.fdata(k_fd),
		.fbytes(k_fn),
		.busy(crc_busy),
		.result(crc_res)
	);
endmodule

// ### tb/pdwc_mem.sv
`timescale 1ns/100ps
// ****************
// memory model
// ****************
module pdwc_mem (
	// clock
	input wire clk_sys,
	// engine bus
	input wire m_req,
	input wire m_write,
	input wire [31:0] m_addr,
	input wire [31:0] m_wdata,
	output reg m_ack,
	output reg [31:0] m_rdata,
	output reg m_err,
	// scenario knobs
	input wire [1:0] slow,
	input wire err_on
);
	reg [31:0] mem [0:255];
	reg [1:0] wt;
	integer i;
	// recognisable pattern
	initial begin
		for (i = 0; i < 256; i = i + 1) mem[i] = 32'h5a5a0000 + i;
		wt = 2'h0;
		m_ack = 1'b0;
		m_err = 1'b0;
		m_rdata = 32'h0;
	end
	// idle data toggles so stale reads never pass
	always @(posedge clk_sys) begin
		m_ack <= 1'b0;
		m_err <= 1'b0;
		m_rdata <= ~m_rdata;
		if (m_req && !m_ack) begin
			if (wt != slow) begin
				wt <= wt + 2'h1;
			end else begin
				wt <= 2'h0;
				m_ack <= 1'b1;
				m_err <= err_on;
				if (m_write) mem[m_addr[9:2]] <= m_wdata;
				else m_rdata <= mem[m_addr[9:2]];
			end
		end
	end
endmodule

// ### tb/pdwc_properties.sv
`timescale 1ns/100ps
// ****************
// bus checker
// ****************
module pdwc_props (
	// clock
	input wire clk_sys,
	input wire rst,
	// register bus
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// data mover
	input wire m_req,
	input wire m_write,
	input wire [31:0] m_addr,
	input wire m_ack,
	input wire m_err
);
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (rst);
	// both write halves in one edge
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_bad_ack;
		m_req && m_ack && m_err;
	endsequence
	// feed writes may stall, so allow a few cycles
	a_wr_answer: assert property (s_wr_taken |-> ##[1:8] s_axi_bvalid)
		else $error("write unanswered");
	a_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("address taken twice");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("response dropped");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read overlap");
	a_req_hold: assert property (m_req && !m_ack |=> m_req && $stable(m_addr) && $stable(m_write))
		else $error("request changed");
	a_err_halt: assert property (s_bad_ack |=> !m_req)
		else $error("ran on after error");
endmodule
bind pdwc_top pdwc_props u_props (.*);

// ### tb/testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end
module testbench;
	// ****************
	// bench
	// ****************
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, err_on = 1'b0;
	logic [15:0] per_req = 16'h0;
	logic [1:0] slow = 2'h0, rs;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp, m_size;
	wire [31:0] s_axi_rdata, m_addr, m_wdata, m_rdata;
	wire m_req, m_write, m_ack, m_err, irq;
	integer bad_count = 0, tests_run = 0;
	pdwc_top uut (.*);
	pdwc_mem u_mem (.*);
	initial forever #5 clk_sys = ~clk_sys;
	task axi_wr(input [11:0] a, input [31:0] d);
		integer n;
		begin
			n = 0;
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			do begin
				@(posedge clk_sys);
				if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
				if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
				n++;
			end while (s_axi_bvalid !== 1'b1 && n < 100);
			rs = s_axi_bresp;
			if (n >= 100) bad_count++;
		end
	endtask
	task axi_rd(input [11:0] a);
		integer n;
		begin
			n = 0;
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			do begin
				@(posedge clk_sys);
				if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
				n++;
			end while (s_axi_rvalid !== 1'b1 && n < 100);
			if (n >= 100) bad_count++;
			rd = s_axi_rdata;
			rs = s_axi_rresp;
		end
	endtask
	// bounded poll of one status bit
	task poll(input [11:0] a, input integer b);
		integer n;
		begin
			rd = 32'h0;
			for (n = 0; n < 200 && rd[b] !== 1'b1; n++) axi_rd(a);
			if (rd[b] !== 1'b1) bad_count++;
		end
	endtask
	task ch_go(input [3:0] c, input [31:0] ctl, input [31:0] s, input [31:0] d, input [31:0] n);
		begin
			axi_wr({3'h0, c, 5'h0}, ctl | 32'h1);
			axi_wr({3'h0, c, 5'h4}, s);
			axi_wr({3'h0, c, 5'h8}, d);
			axi_wr({3'h0, c, 5'hc}, n);
			axi_wr({3'h0, c, 5'h0}, ctl | 32'h800001);
		end
	endtask
	// plain msb-first checksum, low byte fed first
	function [31:0] crc_word(input [1:0] m, input [31:0] d);
		reg [31:0] c, p;
		integer w, i;
		begin
			c = 32'h0;
			w = (m == 2'h1) ? 8 : (m == 2'h3) ? 32 : 16;
			p = m == 2'h0 ? 32'h1021 : m == 2'h1 ? 32'h7 : m == 2'h2 ? 32'h8005 : 32'h04c11db7;
			for (i = 0; i < 32; i++) begin
				if (c[w - 1] ^ d[(i / 8) * 8 + 7 - i % 8]) c = (c << 1) ^ p;
				else c = c << 1;
			end
			crc_word = (w == 32) ? c : c & ((32'h1 << w) - 32'h1);
		end
	endfunction
	task t_regs;
		begin
			axi_rd(12'h20c);
			`CHK(rd, 32'hffffffff)
			axi_wr(12'h20c, 32'h1234abcd);
			axi_rd(12'h20c);
			`CHK(rd, 32'h1234abcd)
			// unmapped space answers with an error
			axi_rd(12'h400);
			`CHK({rs, rd}, {2'h2, 32'h0})
			axi_wr(12'h400, 32'h1);
			`CHK(rs, 2'h2)
			$display("test regs ended");
		end
	endtask
	task t_copy;
		begin
			axi_wr(12'h014, 32'h1);
			ch_go(4'h0, 32'h0, 32'h10, 32'h80, 32'h8);
			poll(12'h018, 0);
			`CHK(u_mem.mem[33], 32'h5a5a0005)
			`CHK(u_mem.mem[34], 32'h5a5a0022)
			`CHK(irq, 1'b1)
			axi_rd(12'h000);
			`CHK(rd[23], 1'b0)
			axi_wr(12'h018, 32'h1);
			axi_rd(12'h018);
			`CHK({irq, rd[1:0]}, 3'h0)
			slow <= 2'h3;
			// destination held fixed, slow memory
			ch_go(4'h1, 32'h80, 32'h20, 32'hc0, 32'hc);
			poll(12'h038, 0);
			`CHK({u_mem.mem[48], u_mem.mem[49]}, {32'h5a5a000a, 32'h5a5a0031})
			slow <= 2'h0;
			$display("test copy ended");
		end
	endtask
	task t_error;
		begin
			err_on <= 1'b1;
			ch_go(4'h2, 32'h0, 32'h40, 32'he0, 32'h4);
			poll(12'h058, 1);
			axi_rd(12'h040);
			`CHK(rd[23], 1'b0)
			err_on <= 1'b0;
			axi_wr(12'h058, 32'h3);
			axi_wr(12'h040, 32'h2);
			ch_go(4'h2, 32'h0, 32'h40, 32'he0, 32'h4);
			poll(12'h058, 0);
			`CHK(u_mem.mem[56], 32'h5a5a0010)
			$display("test error ended");
		end
	endtask
	task t_periph;
		begin
			// select line 5 for channel 3 before start
			axi_wr(12'h300, 32'h05000000);
			ch_go(4'h3, 32'h80004, 32'h30, 32'h100, 32'h1);
			axi_rd(12'h078);
			`CHK({rd[0], u_mem.mem[64]}, {1'b0, 32'h5a5a0040})
			per_req <= 16'h20;
			@(posedge clk_sys iff m_req);
			`CHK(m_size, 2'h0)
			poll(12'h078, 0);
			`CHK(u_mem.mem[64], 32'h5a5a000c)
			per_req <= 16'h0;
			$display("test periph ended");
		end
	endtask
	task t_crc;
		integer m;
		begin
			for (m = 0; m < 4; m++) begin
				axi_wr(12'h20c, 32'h0);
				axi_wr(12'h200, (m << 30) | 32'h20000003);
				axi_rd(12'h200);
				`CHK(rd, (m << 30) | 32'h20000001)
				axi_wr(12'h210, 32'h04030201);
				// a word feed takes four clocks
				repeat (4) @(posedge clk_sys);
				axi_rd(12'h214);
				`CHK(rd, crc_word(m[1:0], 32'h04030201))
			end
			axi_wr(12'h204, 32'h10);
			axi_wr(12'h208, 32'h4);
			axi_wr(12'h20c, 32'h0);
			axi_wr(12'h200, 32'hc0000003);
			axi_wr(12'h200, 32'hc0800001);
			poll(12'h218, 0);
			axi_rd(12'h214);
			`CHK(rd, crc_word(2'h3, 32'h5a5a0004))
			axi_wr(12'h200, 32'hc8000001);
			axi_rd(12'h214);
			`CHK(rd, ~crc_word(2'h3, 32'h5a5a0004))
			$display("test checksum ended");
		end
	endtask
	task complete_run;
		begin
			$display("compares %0d mismatches %0d", tests_run, bad_count);
			if (bad_count == 0 && tests_run > 0) begin
				$display("No errors found");
			end else begin
				$display("Errors were found");
			end
			$finish;
		end
	endtask
	// whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		complete_run;
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_regs;
		t_copy;
		t_error;
		t_periph;
		t_crc;
		complete_run;
	end
endmodule
